// File: pkg/dcfc_pkg.sv
// package: constants and types of the diagnostic and cache flush command block
package dcfc_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int REG_W  = 8;
  localparam int EV_W   = 3;

  // register byte addresses
  localparam logic [ADDR_W-1:0] ADDR_COMMAND = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_ERROR   = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_STATUS  = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_ST  = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MSK = 8'h10;

  // command codes
  localparam logic [REG_W-1:0] CMD_DIAG      = 8'h90;
  localparam logic [REG_W-1:0] CMD_FLUSH     = 8'he7;
  localparam logic [REG_W-1:0] CMD_FLUSH_EXT = 8'hea;

  // completion flag positions
  localparam int ST_BSY  = 7;
  localparam int ST_RDY  = 6;
  localparam int ST_DF   = 5;
  localparam int ST_DSC  = 4;
  localparam int ST_DRQ  = 3;
  localparam int ST_ERR  = 0;
  // error flag positions
  localparam int ER_ABT  = 2;

  localparam logic [REG_W-1:0] STATUS_RESET = 8'h50;
  localparam logic [REG_W-1:0] ERROR_RESET  = 8'h00;
  localparam logic [REG_W-1:0] ERROR_ABORT  = 8'h04;
  localparam logic [REG_W-1:0] REG_ZERO     = 8'h00;

  // interrupt event bits
  localparam int EV_DONE = 0;
  localparam int EV_FAIL = 1;
  localparam int EV_REJ  = 2;
  localparam logic [EV_W-1:0] EV_NONE = 3'h0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [2:0] {
    SEL_COMMAND = 3'b000,
    SEL_ERROR   = 3'b001,
    SEL_STATUS  = 3'b010,
    SEL_IRQ_ST  = 3'b011,
    SEL_IRQ_MSK = 3'b100,
    SEL_NONE    = 3'b111
  } dcfc_sel_t;

  typedef enum logic [1:0] {
    CS_IDLE  = 2'b00,
    CS_DIAG  = 2'b01,
    CS_FLUSH = 2'b10
  } dcfc_state_t;

endpackage : dcfc_pkg

// File: logic/dcfc_irq_bits.sv
// sticky event bits with write-one-to-clear, mask and one level interrupt
module dcfc_irq_bits
  import dcfc_pkg::*;
(
  // clock and reset
  input  wire logic            i_mclk,
  input  wire logic            i_reset_n,
  // events and software access
  input  wire logic [EV_W-1:0] i_event,
  input  wire logic [EV_W-1:0] i_clear,
  input  wire logic            i_mask_wr,
  input  wire logic [EV_W-1:0] i_mask_data,
  // state
  output logic      [EV_W-1:0] o_status,
  output logic      [EV_W-1:0] o_mask,
  output logic                 o_irq
);

  logic [EV_W-1:0] stat_next;

  genvar gi;
  generate
    for (gi = 0; gi < EV_W; gi++) begin : g_bit
      // set wins over a clear in the same cycle
      assign stat_next[gi] = i_event[gi] | (o_status[gi] & ~i_clear[gi]);
      always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
          o_status[gi] <= 1'b0;
        end else begin
          o_status[gi] <= stat_next[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      o_mask <= EV_NONE;
    end else if (i_mask_wr) begin
      o_mask <= i_mask_data;
    end
  end

  // built from next state so the irq flop tracks status with no extra lag
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(stat_next & (i_mask_wr ? i_mask_data : o_mask));
    end
  end

endmodule : dcfc_irq_bits

// File: logic/dcfc_cmd_top.sv
// command interpreter for diagnostic and cache flush commands, axi4-lite slave
//
// Design decisions made here: the register addresses and the AXI4-Lite slave port.
module dcfc_cmd_top
  import dcfc_pkg::*;
(
  // clock and reset
  input  wire logic              i_mclk,
  input  wire logic              i_reset_n,
  // axi4-lite write address
  input  wire logic              i_awvalid,
  output logic                   o_awready,
  input  wire logic [ADDR_W-1:0] i_awaddr,
  input  wire logic [2:0]        i_awprot,
  // axi4-lite write data
  input  wire logic              i_wvalid,
  output logic                   o_wready,
  input  wire logic [DATA_W-1:0] i_wdata,
  input  wire logic [3:0]        i_wstrb,
  // axi4-lite write response
  output logic                   o_bvalid,
  input  wire logic              i_bready,
  output logic      [1:0]        o_bresp,
  // axi4-lite read address
  input  wire logic              i_arvalid,
  output logic                   o_arready,
  input  wire logic [ADDR_W-1:0] i_araddr,
  input  wire logic [2:0]        i_arprot,
  // axi4-lite read data
  output logic                   o_rvalid,
  input  wire logic              i_rready,
  output logic      [DATA_W-1:0] o_rdata,
  output logic      [1:0]        o_rresp,
  // diagnostic engine
  output logic                   o_diag_start,
  input  wire logic              i_diag_done,
  input  wire logic [REG_W-1:0]  i_diag_code,
  // write cache engine
  output logic                   o_flush_start,
  input  wire logic              i_flush_done,
  input  wire logic              i_flush_fail,
  input  wire logic              i_cache_dirty,
  // interrupt and state
  output logic                   o_busy,
  output logic                   o_irq
);

  // address decode, shared by read and write paths
  function automatic dcfc_sel_t dcfc_decode(input logic [ADDR_W-1:0] addr);
    dcfc_sel_t s;
    s = SEL_NONE;
    case (addr)
      ADDR_COMMAND: s = SEL_COMMAND;
      ADDR_ERROR:   s = SEL_ERROR;
      ADDR_STATUS:  s = SEL_STATUS;
      ADDR_IRQ_ST:  s = SEL_IRQ_ST;
      ADDR_IRQ_MSK: s = SEL_IRQ_MSK;
      default:      s = SEL_NONE;
    endcase
    return s;
  endfunction : dcfc_decode

  // write channel holding state
  logic              aw_hold_reg;
  logic              aw_hold_next;
  logic [ADDR_W-1:0] awaddr_reg;
  logic              w_hold_reg;
  logic              w_hold_next;
  logic [DATA_W-1:0] wdata_reg;
  logic [3:0]        wstrb_reg;
  logic              bvalid_next;
  logic              aw_take;
  logic              w_take;
  logic              do_write;
  dcfc_sel_t         wsel;
  logic              low_lane;

  // read channel
  logic              rvalid_next;
  logic              ar_take;

  // command state
  dcfc_state_t       state_reg;
  logic [REG_W-1:0]  error_reg;
  logic [REG_W-1:0]  status_reg;
  logic              cmd_wr;
  logic [REG_W-1:0]  cmd_code;
  logic [EV_W-1:0]   events;
  logic [EV_W-1:0]   irq_clear;
  logic              mask_wr;
  logic [EV_W-1:0]   irq_status;
  logic [EV_W-1:0]   irq_mask;
  logic              flush_good;
  logic              flush_bad;

  assign aw_take  = i_awvalid & o_awready;
  assign w_take   = i_wvalid & o_wready;
  // protection bits carry no meaning here
  assign do_write = aw_hold_reg & w_hold_reg & ~o_bvalid;
  assign wsel     = dcfc_decode(awaddr_reg);
  assign low_lane = wstrb_reg[0];

  assign aw_hold_next = do_write ? 1'b0 : (aw_hold_reg | aw_take);
  assign w_hold_next  = do_write ? 1'b0 : (w_hold_reg | w_take);
  assign bvalid_next  = do_write | (o_bvalid & ~i_bready);

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      aw_hold_reg <= 1'b0;
      awaddr_reg  <= '0;
    end else begin
      aw_hold_reg <= aw_hold_next;
      if (aw_take) begin
        awaddr_reg <= i_awaddr;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      w_hold_reg <= 1'b0;
      wdata_reg  <= '0;
      wstrb_reg  <= '0;
    end else begin
      w_hold_reg <= w_hold_next;
      if (w_take) begin
        wdata_reg <= i_wdata;
        wstrb_reg <= i_wstrb;
      end
    end
  end

  // ready flops follow next hold state, so no extra item slips in
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      o_awready <= 1'b0;
      o_wready  <= 1'b0;
    end else begin
      o_awready <= ~aw_hold_next & ~bvalid_next;
      o_wready  <= ~w_hold_next & ~bvalid_next;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      o_bvalid <= 1'b0;
      o_bresp  <= RESP_OKAY;
    end else begin
      o_bvalid <= bvalid_next;
      if (do_write) begin
        o_bresp <= (wsel == SEL_NONE) ? RESP_DECERR : RESP_OKAY;
      end
    end
  end

  // register side effects of a write
  assign cmd_wr    = do_write & low_lane & (wsel == SEL_COMMAND);
  assign cmd_code  = wdata_reg[REG_W-1:0];
  assign mask_wr   = do_write & low_lane & (wsel == SEL_IRQ_MSK);
  assign irq_clear = (do_write & low_lane & (wsel == SEL_IRQ_ST)) ? wdata_reg[EV_W-1:0] : EV_NONE;

  // read path: data captured at the address handshake
  assign ar_take     = i_arvalid & o_arready;
  assign rvalid_next = ar_take | (o_rvalid & ~i_rready);

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b0;
    end else begin
      o_arready <= ~rvalid_next;
      o_rvalid  <= rvalid_next;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      o_rdata <= '0;
      o_rresp <= RESP_OKAY;
    end else if (ar_take) begin
      o_rresp <= RESP_OKAY;
      case (dcfc_decode(i_araddr))
        SEL_COMMAND: o_rdata <= '0;
        SEL_ERROR:   o_rdata <= {{(DATA_W-REG_W){1'b0}}, error_reg};
        SEL_STATUS:  o_rdata <= {{(DATA_W-REG_W){1'b0}}, status_reg};
        SEL_IRQ_ST:  o_rdata <= {{(DATA_W-EV_W){1'b0}}, irq_status};
        SEL_IRQ_MSK: o_rdata <= {{(DATA_W-EV_W){1'b0}}, irq_mask};
        default: begin
          o_rdata <= '0;
          o_rresp <= RESP_DECERR;
        end
      endcase
    end
  end

  // completion of a flush
  // good only when clean
  assign flush_good = i_flush_done & ~i_flush_fail & ~i_cache_dirty;
  assign flush_bad  = i_flush_done & (i_flush_fail | i_cache_dirty);

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      state_reg <= CS_IDLE;
    end else begin
      case (state_reg)
        CS_IDLE: begin
          if (cmd_wr) begin
            case (cmd_code)
              CMD_DIAG:      state_reg <= CS_DIAG;
              CMD_FLUSH,
              CMD_FLUSH_EXT: state_reg <= CS_FLUSH;
              default:       state_reg <= CS_IDLE;
            endcase
          end
        end
        CS_DIAG: begin
          if (i_diag_done) begin
            state_reg <= CS_IDLE;
          end
        end
        CS_FLUSH: begin
          if (i_flush_done) begin
            state_reg <= CS_IDLE;
          end
        end
        default: state_reg <= CS_IDLE;
      endcase
    end
  end

  // start pulses to the engines, one cycle each
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      o_diag_start  <= 1'b0;
      o_flush_start <= 1'b0;
    end else begin
      o_diag_start  <= (state_reg == CS_IDLE) & cmd_wr & (cmd_code == CMD_DIAG);
      o_flush_start <= (state_reg == CS_IDLE) & cmd_wr &
                       ((cmd_code == CMD_FLUSH) | (cmd_code == CMD_FLUSH_EXT));
    end
  end

  // error register
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      error_reg <= ERROR_RESET;
    end else begin
      case (state_reg)
        CS_IDLE: begin
          if (cmd_wr) begin
            // unknown codes abort, known ones start clean
            case (cmd_code)
              CMD_DIAG,
              CMD_FLUSH,
              CMD_FLUSH_EXT: error_reg <= REG_ZERO;
              default:       error_reg <= ERROR_ABORT;
            endcase
          end
        end
        CS_DIAG: begin
          if (i_diag_done) begin
            error_reg <= i_diag_code;
          end
        end
        CS_FLUSH: begin
          if (flush_bad) begin
            error_reg <= ERROR_ABORT;
          end else if (flush_good) begin
            error_reg <= REG_ZERO;
          end
        end
        default: error_reg <= error_reg;
      endcase
    end
  end

  // completion flags register
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      status_reg <= STATUS_RESET;
    end else begin
      case (state_reg)
        CS_IDLE: begin
          if (cmd_wr) begin
            case (cmd_code)
              CMD_DIAG,
              CMD_FLUSH,
              CMD_FLUSH_EXT: begin
                status_reg         <= REG_ZERO;
                status_reg[ST_BSY] <= 1'b1;
              end
              default: begin
                status_reg         <= STATUS_RESET;
                status_reg[ST_ERR] <= 1'b1;
              end
            endcase
          end
        end
        CS_DIAG: begin
          // diagnostic code carries the verdict, error flag stays low
          if (i_diag_done) begin
            status_reg <= STATUS_RESET;
          end
        end
        CS_FLUSH: begin
          if (i_flush_done) begin
            status_reg         <= STATUS_RESET;
            status_reg[ST_ERR] <= flush_bad;
          end
        end
        default: status_reg <= status_reg;
      endcase
    end
  end

  // a command written while busy is dropped and flagged
  always_comb begin
    events = EV_NONE;
    events[EV_DONE] = ((state_reg == CS_DIAG) & i_diag_done) | ((state_reg == CS_FLUSH) & i_flush_done);
    events[EV_FAIL] = ((state_reg == CS_FLUSH) & flush_bad) | ((state_reg == CS_IDLE) & cmd_wr &
                      (cmd_code != CMD_DIAG) & (cmd_code != CMD_FLUSH) & (cmd_code != CMD_FLUSH_EXT));
    events[EV_REJ]  = (state_reg != CS_IDLE) & cmd_wr;
  end

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      o_busy <= 1'b0;
    end else begin
      o_busy <= ((state_reg == CS_IDLE) & cmd_wr &
                 ((cmd_code == CMD_DIAG) | (cmd_code == CMD_FLUSH) | (cmd_code == CMD_FLUSH_EXT))) |
                ((state_reg == CS_DIAG) & ~i_diag_done) |
                ((state_reg == CS_FLUSH) & ~i_flush_done);
    end
  end

  dcfc_irq_bits u_irq (
    .i_mclk      (i_mclk),
    .i_reset_n   (i_reset_n),
    .i_event     (events),
    .i_clear     (irq_clear),
    .i_mask_wr   (mask_wr),
    .i_mask_data (wdata_reg[EV_W-1:0]),
    .o_status    (irq_status),
    .o_mask      (irq_mask),
    .o_irq       (o_irq)
  );

endmodule : dcfc_cmd_top

// File: dv/dcfc_engine_model.sv
// partner model: diagnostic engine and write cache engine answering start pulses
module dcfc_engine_model
  import dcfc_pkg::*;
(
  // clock and reset
  input  wire logic             i_mclk,
  input  wire logic             i_reset_n,
  // start pulses and bench settings
  input  wire logic             i_diag_start,
  input  wire logic             i_flush_start,
  input  wire logic [REG_W-1:0] i_code,
  input  wire logic             i_fail,
  input  wire logic             i_dirty,
  input  int                    i_delay,
  // answers
  output logic                  o_diag_done,
  output logic                  o_flush_done,
  output logic      [REG_W-1:0] o_diag_code,
  output logic                  o_flush_fail,
  output logic                  o_cache_dirty,
  output int                    o_starts
);
  timeunit 1ns;
  timeprecision 1ps;
  int   cnt;
  logic is_diag;
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      cnt      <= 0;
      is_diag  <= 1'b0;
      o_starts <= 0;
    end else if (i_diag_start || i_flush_start) begin
      cnt      <= i_delay;
      is_diag  <= i_diag_start;
      o_starts <= o_starts + 1;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
    end
  end
  assign o_diag_done  = (cnt == 1) && is_diag;
  assign o_flush_done = (cnt == 1) && !is_diag;
  assign o_diag_code   = o_diag_done ? i_code : ~i_code;
  assign o_cache_dirty = o_flush_done ? i_dirty : cnt[0];
  // toggling junk outside the done cycle, valid only when done
  assign o_flush_fail  = o_flush_done ? i_fail : ~cnt[0];
endmodule : dcfc_engine_model

// File: dv/dcfc_cmd_monitor.sv
// checker: command start, busy and completion relations at the ports
module dcfc_cmd_monitor
  import dcfc_pkg::*;
(
  input wire logic              i_mclk,
  input wire logic              i_reset_n,
  input wire logic              o_diag_start,
  input wire logic              o_flush_start,
  input wire logic              i_diag_done,
  input wire logic              i_flush_done,
  input wire logic              o_busy,
  input wire logic              o_rvalid,
  input wire logic              i_rready,
  input wire logic [DATA_W-1:0] o_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);
  sequence s_start;
    o_diag_start || o_flush_start;
  endsequence
  sequence s_done;
    i_diag_done || i_flush_done;
  endsequence
  a_diag_pulse: assert property (o_diag_start |=> !o_diag_start && o_busy)
    else $error("diag start not one pulse");
  a_flush_pulse: assert property (o_flush_start |=> !o_flush_start && o_busy)
    else $error("flush start not one pulse");
  a_start_excl: assert property (!(o_diag_start && o_flush_start))
    else $error("two engines started");
  a_busy_from_start: assert property ($rose(o_busy) |-> s_start)
    else $error("busy without start");
  a_busy_held: assert property (o_busy && !i_diag_done && !i_flush_done |=> o_busy)
    else $error("busy dropped before done");
  a_done_to_idle: assert property (o_busy ##0 s_done |=> !o_busy)
    else $error("busy kept after done");
  a_no_restart: assert property (o_busy && $past(o_busy) |-> !(o_diag_start || o_flush_start))
    else $error("start while busy");
  a_rdata_held: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read data changed while held");
endmodule : dcfc_cmd_monitor

bind dcfc_cmd_top dcfc_cmd_monitor u_mon (
  .i_mclk, .i_reset_n, .o_diag_start, .o_flush_start, .i_diag_done, .i_flush_done,
  .o_busy, .o_rvalid, .i_rready, .o_rdata
);

// File: dv/dcfc_cmd_top_tb.sv
// testbench: register tasks and command sequences for the command block
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; $display("wrong value %s exp %h got %h", n, e, g); end end
module dcfc_cmd_top_tb
  import dcfc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic              i_mclk = 0, i_reset_n = 0;
  logic              i_awvalid = 0, i_wvalid = 0, i_bready = 0, i_arvalid = 0, i_rready = 0;
  logic [ADDR_W-1:0] i_awaddr = 8'h00, i_araddr = 8'h00;
  logic [DATA_W-1:0] i_wdata = 32'h0000_0000;
  logic [3:0]        i_wstrb = 4'hf;
  logic              o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_diag_start, o_flush_start, o_busy, o_irq;
  logic [1:0]        o_bresp, o_rresp;
  logic [DATA_W-1:0] o_rdata;
  logic              i_diag_done, i_flush_done, i_flush_fail, i_cache_dirty;
  logic [REG_W-1:0]  i_diag_code;
  logic [REG_W-1:0]  m_code = 8'h00;
  logic              m_fail = 0, m_dirty = 0;
  logic [REG_W-1:0]  codes [3] = '{8'h01, 8'h82, 8'h7f};
  int                m_delay = 20, n_fail = 0, n_tests = 0, starts;

  always #2.5 i_mclk = ~i_mclk;

  dcfc_cmd_top dut (
    .i_mclk, .i_reset_n, .i_awvalid, .o_awready, .i_awaddr, .i_awprot(3'h0), .i_wvalid, .o_wready,
    .i_wdata, .i_wstrb, .o_bvalid, .i_bready, .o_bresp, .i_arvalid, .o_arready, .i_araddr,
    .i_arprot(3'h0), .o_rvalid, .i_rready, .o_rdata, .o_rresp, .o_diag_start, .i_diag_done,
    .i_diag_code, .o_flush_start, .i_flush_done, .i_flush_fail, .i_cache_dirty, .o_busy, .o_irq
  );

  dcfc_engine_model u_eng (
    .i_mclk, .i_reset_n, .i_diag_start(o_diag_start), .i_flush_start(o_flush_start),
    .i_code(m_code), .i_fail(m_fail), .i_dirty(m_dirty), .i_delay(m_delay),
    .o_diag_done(i_diag_done), .o_flush_done(i_flush_done), .o_diag_code(i_diag_code),
    .o_flush_fail(i_flush_fail), .o_cache_dirty(i_cache_dirty), .o_starts(starts)
  );

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic [1:0] er = RESP_OKAY);
    @(posedge i_mclk);
    i_awvalid <= 1'b1;
    i_wvalid  <= 1'b1;
    i_awaddr  <= a;
    i_wdata   <= d;
    i_bready  <= 1'b1;
    do begin
      @(posedge i_mclk);
      // released payload shows garbage, design must have latched it
      if (o_awready) begin
        i_awvalid <= 1'b0;
        i_awaddr  <= ~a;
      end
      if (o_wready) begin
        i_wvalid <= 1'b0;
        i_wdata  <= ~d;
      end
    end while (!o_bvalid);
    `CHK("bresp", er, o_bresp)
    i_bready <= 1'b0;
  endtask : wr

  task automatic rchk(input string n, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e,
                      input logic [1:0] er = RESP_OKAY, input int lag = 0);
    @(posedge i_mclk);
    i_arvalid <= 1'b1;
    i_araddr  <= a;
    i_rready  <= (lag == 0);
    do begin
      @(posedge i_mclk);
      if (o_arready) begin
        i_arvalid <= 1'b0;
        i_araddr  <= ~a;
      end
      // late ready keeps read data waiting a few cycles
      if (lag == 1) i_rready <= 1'b1;
      if (lag > 0) lag--;
    end while (!(o_rvalid && i_rready));
    `CHK(n, e, o_rdata)
    `CHK(n, er, o_rresp)
    i_rready <= 1'b0;
  endtask : rchk

  // bounded wait, engine answers in a few dozen cycles
  task automatic wait_idle;
    int t;
    t = 0;
    @(posedge i_mclk);
    #1;
    while (o_busy === 1'b1 && t < 300) begin
      @(posedge i_mclk);
      #1;
      t++;
    end
    `CHK("busy", 1'b0, o_busy)
  endtask : wait_idle

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run

  initial begin
    #50000;
    n_fail++;
    complete_run();
  end

  initial begin
    repeat (2) @(posedge i_mclk);
    i_reset_n <= 1'b1;
    rchk("error", ADDR_ERROR, 32'h0000_0000);
    rchk("status", ADDR_STATUS, 32'h0000_0050);
    rchk("irq st", ADDR_IRQ_ST, 32'h0000_0000);
    rchk("unmapped", 8'h20, 32'h0000_0000, RESP_DECERR);
    wr(8'h40, 32'h0000_0000, RESP_DECERR);
    wr(ADDR_IRQ_MSK, 32'h0000_0001);
    rchk("mask", ADDR_IRQ_MSK, 32'h0000_0001);
    $display("test reset done");
    foreach (codes[i]) begin
      m_code <= codes[i];
      wr(ADDR_COMMAND, 32'(CMD_DIAG));
      rchk("diag busy", ADDR_STATUS, 32'h0000_0080);
      wait_idle();
      rchk("diag code", ADDR_ERROR, 32'(codes[i]), RESP_OKAY, 3);
      rchk("diag status", ADDR_STATUS, 32'h0000_0050);
      `CHK("irq on", 1'b1, o_irq)
      wr(ADDR_IRQ_ST, 32'h0000_0007);
      #1;
      `CHK("irq off", 1'b0, o_irq)
    end
    $display("test diag done");
    // masked: status bits still set, line stays low
    wr(ADDR_IRQ_MSK, 32'h0000_0000);
    for (int i = 0; i < 6; i++) begin
      m_dirty <= (i % 3 == 1);
      m_fail  <= (i % 3 == 2);
      if (i < 3) wr(ADDR_COMMAND, 32'(CMD_FLUSH));
      else wr(ADDR_COMMAND, 32'(CMD_FLUSH_EXT));
      rchk("flush busy", ADDR_STATUS, 32'h0000_0080);
      wait_idle();
      `CHK("irq masked", 1'b0, o_irq)
      rchk("flush status", ADDR_STATUS, (i % 3 != 0) ? 32'h0000_0051 : 32'h0000_0050);
      rchk("flush error", ADDR_ERROR, (i % 3 != 0) ? 32'h0000_0004 : 32'h0000_0000);
      rchk("flush irq", ADDR_IRQ_ST, (i % 3 != 0) ? 32'h0000_0003 : 32'h0000_0001);
      wr(ADDR_IRQ_ST, 32'h0000_0007);
    end
    $display("test flush done");
    m_dirty <= 1'b0;
    m_fail  <= 1'b0;
    m_delay <= 60;
    wr(ADDR_COMMAND, 32'(CMD_FLUSH));
    wr(ADDR_COMMAND, 32'(CMD_DIAG));
    wait_idle();
    rchk("reject irq", ADDR_IRQ_ST, 32'h0000_0005);
    rchk("reject status", ADDR_STATUS, 32'h0000_0050);
    wr(ADDR_IRQ_ST, 32'h0000_0007);
    // low byte lane off: command write must have no effect
    i_wstrb <= 4'he;
    wr(ADDR_COMMAND, 32'(CMD_DIAG));
    i_wstrb <= 4'hf;
    rchk("lane status", ADDR_STATUS, 32'h0000_0050);
    rchk("lane irq", ADDR_IRQ_ST, 32'h0000_0000);
    wr(ADDR_COMMAND, 32'h0000_0055);
    rchk("unknown status", ADDR_STATUS, 32'h0000_0051);
    rchk("unknown irq", ADDR_IRQ_ST, 32'h0000_0002);
    `CHK("starts", 10, starts)
    $display("test reject done");
    complete_run();
  end
endmodule : dcfc_cmd_top_tb
